// *** rtl/ptc_pkg.sv ***
// constants for the periodic timer pin control block
package ptc_pkg;
  localparam int        CNT_W          = 10;
  localparam logic [2:0] ADDR_CTRL2    = 3'h0;
  localparam logic [2:0] ADDR_CNT_LO   = 3'h1;
  localparam logic [2:0] ADDR_CNT_HI   = 3'h2;
  localparam logic [2:0] ADDR_CMPA_LO  = 3'h3;
  localparam logic [2:0] ADDR_CMPA_HI  = 3'h4;
  localparam logic [7:0] CTRL2_RESET   = 8'h00;
  localparam int        BIT_MODE_HI    = 7;
  localparam int        BIT_MODE_LO    = 6;
  localparam int        BIT_PFS_HI     = 5;
  localparam int        BIT_PFS_LO     = 4;
  localparam int        BIT_INIT_LVL   = 3;
  localparam int        BIT_POL_INV    = 2;
  localparam int        BIT_CAP_SRC    = 1;
  localparam int        BIT_CLR_SEL    = 0;
  localparam logic [1:0] MODE_CMP      = 2'h0;
  localparam logic [1:0] MODE_CAP      = 2'h1;
  localparam logic [1:0] MODE_PWM      = 2'h2;
  localparam logic [1:0] MODE_TMR      = 2'h3;
  localparam logic [1:0] PFS_00        = 2'h0;
  localparam logic [1:0] PFS_01        = 2'h1;
  localparam logic [1:0] PFS_10        = 2'h2;
  localparam logic [1:0] PFS_11        = 2'h3;
endpackage : ptc_pkg

// *** rtl/ptc_timer.sv ***
// periodic timer pin control, counter and compare a registers
`timescale 1ns/1ps
module ptc_timer
  import ptc_pkg::*;
(
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // register port
  input  wire logic [2:0]           regAddr,
  input  wire logic [7:0]           regWdata,
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  output logic      [7:0]           regRdata,
  // rest of the timer
  input  wire logic                 counterOnControl,
  input  wire logic                 countTick,
  input  wire logic [ptc_pkg::CNT_W-1:0] compareP,
  output logic                      singlePulseStop,
  // pins
  input  wire logic                 captureInputPin,
  input  wire logic                 externalClockPin,
  output logic                      timerOutputPin,
  output logic                      captureEvent,
  // status
  output logic                      matchA,
  output logic                      matchP
);
  import ptc_pkg::*;

  logic [7:0]       ctrl2_q;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] cmpA_q;
  logic [7:0]       loBuf_q;
  logic             onPrev_q;
  logic             outLvl_q;
  logic             trigPrev_q;
  logic [1:0]       mode;
  logic [1:0]       pinFunc;
  logic             initLvl;
  logic             onRise;
  logic             onFall;
  logic             atMax;
  logic             clearCnt;
  logic             trig;
  logic             pwmActive;
  logic             rawOut;

  assign mode    = ctrl2_q[BIT_MODE_HI:BIT_MODE_LO];
  assign pinFunc = ctrl2_q[BIT_PFS_HI:BIT_PFS_LO];
  assign initLvl = ctrl2_q[BIT_INIT_LVL];
  assign onRise  = counterOnControl & ~onPrev_q;
  assign onFall  = ~counterOnControl & onPrev_q;
  assign atMax   = (count_q == {CNT_W{1'b1}});
  assign matchA  = countTick & counterOnControl & (count_q == cmpA_q);
  assign matchP  = countTick & counterOnControl & (count_q == compareP);

  // clear source only matters in compare and timer modes
  always_comb begin
    if ((mode == MODE_CMP) || (mode == MODE_TMR)) begin
      if (ctrl2_q[BIT_CLR_SEL])
        clearCnt = matchA;
      else
        clearCnt = (compareP != '0) ? matchP
                 : (countTick & counterOnControl & atMax);
    end else if (mode == MODE_PWM) begin
      clearCnt = (compareP != '0) ? matchP
               : (countTick & counterOnControl & atMax);
    end else begin
      clearCnt = countTick & counterOnControl & atMax;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) onPrev_q <= 1'b0;
    else     onPrev_q <= counterOnControl;
  end

  // counter: zero on control rise, hold when off
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
    end else if (onRise) begin
      count_q <= '0;
    end else if (counterOnControl && countTick) begin
      if (clearCnt) count_q <= '0;
      else          count_q <= count_q + 1'b1;
    end
  end

  // single pulse ends on match a
  assign singlePulseStop = (mode == MODE_PWM) && (pinFunc == PFS_11)
                           && matchA;

  // compare mode and single pulse output level
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      outLvl_q <= 1'b0;
    end else if (onRise) begin
      outLvl_q <= initLvl;
    end else if (mode == MODE_CMP && matchA) begin
      unique case (pinFunc)
        PFS_00: outLvl_q <= outLvl_q;
        PFS_01: outLvl_q <= 1'b0;
        PFS_10: outLvl_q <= 1'b1;
        PFS_11: outLvl_q <= ~outLvl_q;
      endcase
    end else if (mode == MODE_PWM && pinFunc == PFS_11
                 && (matchA || onFall)) begin
      outLvl_q <= ~initLvl;
    end
  end

  // duty beyond period gives full duty
  assign pwmActive = (count_q < cmpA_q);

  always_comb begin
    unique case (pinFunc)
      PFS_00: rawOut = ~initLvl;
      PFS_01: rawOut = initLvl;
      PFS_10: rawOut = pwmActive ? initLvl : ~initLvl;
      PFS_11: rawOut = outLvl_q;
    endcase
    if (mode == MODE_CMP) rawOut = outLvl_q;
  end

  // output pin undefined in timer mode, held low there and in capture mode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      timerOutputPin <= 1'b0;
    else if (mode == MODE_TMR || mode == MODE_CAP)
      timerOutputPin <= 1'b0;
    else
      timerOutputPin <= rawOut ^ ctrl2_q[BIT_POL_INV];
  end

  // capture trigger source and edge
  assign trig = ctrl2_q[BIT_CAP_SRC] ? externalClockPin
                                     : captureInputPin;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) trigPrev_q <= 1'b0;
    else     trigPrev_q <= trig;
  end

  always_comb begin
    unique case (pinFunc)
      PFS_00: captureEvent = trig & ~trigPrev_q;
      PFS_01: captureEvent = ~trig & trigPrev_q;
      PFS_10: captureEvent = trig ^ trigPrev_q;
      PFS_11: captureEvent = 1'b0;
    endcase
    if (mode != MODE_CAP) captureEvent = 1'b0;
  end

  // registers; low byte shares one buffer for writes and reads
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl2_q <= CTRL2_RESET;
      cmpA_q  <= '0;
      loBuf_q <= 8'h00;
    end else if (regWr) begin
      unique case (regAddr)
        ADDR_CTRL2:   ctrl2_q <= regWdata;
        ADDR_CMPA_LO: loBuf_q <= regWdata;
        ADDR_CMPA_HI: cmpA_q  <= {regWdata[1:0], loBuf_q};
        default:      ;
      endcase
    end else if (regRd) begin
      unique case (regAddr)
        ADDR_CNT_HI:  loBuf_q <= count_q[7:0];
        ADDR_CMPA_HI: loBuf_q <= cmpA_q[7:0];
        default:      ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      unique case (regAddr)
        ADDR_CTRL2:   regRdata <= ctrl2_q;
        ADDR_CNT_LO:  regRdata <= loBuf_q;
        ADDR_CNT_HI:  regRdata <= {6'h00, count_q[9:8]};
        ADDR_CMPA_LO: regRdata <= loBuf_q;
        ADDR_CMPA_HI: regRdata <= {6'h00, cmpA_q[9:8]};
        default:      regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

  // counter behaviour
  a_count_restart: assert property (
    @(posedge sys_clk) disable iff (rst)
    onRise |=> count_q == '0)
    else $error("counter not zeroed on control rise");

  a_count_hold: assert property (
    @(posedge sys_clk) disable iff (rst)
    !counterOnControl && !$rose(counterOnControl) |=> $stable(count_q))
    else $error("counter moved while off");

  a_count_step: assert property (
    @(posedge sys_clk) disable iff (rst)
    counterOnControl && countTick && !onRise && !clearCnt
    |=> count_q == $past(count_q) + 10'h001)
    else $error("counter did not advance on tick");

  a_count_clear: assert property (
    @(posedge sys_clk) disable iff (rst)
    !onRise && clearCnt && counterOnControl && countTick |=> count_q == '0)
    else $error("counter not cleared");

  a_clear_on_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    !onRise && mode == MODE_CMP && ctrl2_q[BIT_CLR_SEL] && matchA
    |=> count_q == '0)
    else $error("match a did not clear counter");

  a_clear_on_p: assert property (
    @(posedge sys_clk) disable iff (rst)
    (mode == MODE_CMP || mode == MODE_TMR) && !ctrl2_q[BIT_CLR_SEL]
    && matchP |-> clearCnt)
    else $error("match p did not clear counter");

  // in compare mode with clear on p, overflow may only clear when compare p is zero
  a_ovf_guard: assert property (
    @(posedge sys_clk) disable iff (rst)
    mode == MODE_CMP && !ctrl2_q[BIT_CLR_SEL] && compareP != '0
    && compareP != count_q && atMax |-> !clearCnt)
    else $error("overflow cleared with compare p set");

  a_pwm_noclr: assert property (
    @(posedge sys_clk) disable iff (rst)
    mode == MODE_PWM && !matchP && !atMax |-> !clearCnt)
    else $error("clear select used in pwm mode");

  a_cap_noclr: assert property (
    @(posedge sys_clk) disable iff (rst)
    mode == MODE_CAP && !atMax |-> !clearCnt)
    else $error("clear select used in capture mode");

  // output level
  a_init_level: assert property (
    @(posedge sys_clk) disable iff (rst)
    onRise |=> outLvl_q == $past(initLvl))
    else $error("output not reset to initial level");

  a_match_low: assert property (
    @(posedge sys_clk) disable iff (rst)
    !onRise && mode == MODE_CMP && matchA && pinFunc == PFS_01
    |=> !outLvl_q)
    else $error("match did not drive low");

  a_match_high: assert property (
    @(posedge sys_clk) disable iff (rst)
    !onRise && mode == MODE_CMP && matchA && pinFunc == PFS_10
    |=> outLvl_q)
    else $error("match did not drive high");

  a_match_hold: assert property (
    @(posedge sys_clk) disable iff (rst)
    !onRise && mode == MODE_CMP && matchA && pinFunc == PFS_00
    |=> $stable(outLvl_q))
    else $error("match changed output in hold code");

  a_match_toggle: assert property (
    @(posedge sys_clk) disable iff (rst)
    !onRise && mode == MODE_CMP && matchA && pinFunc == PFS_11
    |=> outLvl_q != $past(outLvl_q))
    else $error("match did not toggle");

  a_sp_end: assert property (
    @(posedge sys_clk) disable iff (rst)
    !onRise && mode == MODE_PWM && pinFunc == PFS_11 && matchA
    |=> outLvl_q == !$past(initLvl))
    else $error("single pulse did not end on match");

  a_sp_stop: assert property (
    @(posedge sys_clk) disable iff (rst)
    singlePulseStop |-> matchA && mode == MODE_PWM && pinFunc == PFS_11)
    else $error("single pulse stop outside its mode");

  // pin level, one cycle behind the level it shows
  a_pin_polarity: assert property (
    @(posedge sys_clk) disable iff (rst)
    mode == MODE_CMP |=> timerOutputPin ==
      ($past(outLvl_q) ^ $past(ctrl2_q[BIT_POL_INV])))
    else $error("output polarity wrong");

  a_pwm_active: assert property (
    @(posedge sys_clk) disable iff (rst)
    mode == MODE_PWM && pinFunc == PFS_01 |=> timerOutputPin ==
      ($past(initLvl) ^ $past(ctrl2_q[BIT_POL_INV])))
    else $error("forced active level wrong");

  a_pwm_idle: assert property (
    @(posedge sys_clk) disable iff (rst)
    mode == MODE_PWM && pinFunc == PFS_00 |=> timerOutputPin ==
      (!$past(initLvl) ^ $past(ctrl2_q[BIT_POL_INV])))
    else $error("forced inactive level wrong");

  a_pwm_wave: assert property (
    @(posedge sys_clk) disable iff (rst)
    mode == MODE_PWM && pinFunc == PFS_10 |=> timerOutputPin ==
      (($past(count_q < cmpA_q) ? $past(initLvl) : !$past(initLvl))
       ^ $past(ctrl2_q[BIT_POL_INV])))
    else $error("pwm waveform level wrong");

  a_tmr_pin: assert property (
    @(posedge sys_clk) disable iff (rst)
    mode == MODE_TMR |=> !timerOutputPin)
    else $error("output pin driven in timer mode");

  // capture edges
  a_cap_off: assert property (
    @(posedge sys_clk) disable iff (rst)
    pinFunc == PFS_11 |-> !captureEvent)
    else $error("capture fired while disabled");

  a_cap_rise: assert property (
    @(posedge sys_clk) disable iff (rst)
    mode == MODE_CAP && pinFunc == PFS_00 && $rose(trig) |-> captureEvent)
    else $error("rising capture missed");

  a_cap_fall: assert property (
    @(posedge sys_clk) disable iff (rst)
    !$past(rst) && mode == MODE_CAP && pinFunc == PFS_01 && $fell(trig)
    |-> captureEvent)
    else $error("falling capture missed");

  a_cap_both: assert property (
    @(posedge sys_clk) disable iff (rst)
    !$past(rst) && mode == MODE_CAP && pinFunc == PFS_10 && $changed(trig)
    |-> captureEvent)
    else $error("double edge capture missed");

  a_cap_mode: assert property (
    @(posedge sys_clk) disable iff (rst)
    mode != MODE_CAP |-> !captureEvent)
    else $error("capture fired outside capture mode");

  a_cap_source: assert property (
    @(posedge sys_clk) disable iff (rst)
    !$past(rst) && captureEvent |-> (ctrl2_q[BIT_CAP_SRC]
      ? externalClockPin != $past(externalClockPin)
      : captureInputPin != $past(captureInputPin)))
    else $error("capture taken from wrong pin");

  // register port
  a_rd_idle: assert property (
    @(posedge sys_clk) disable iff (rst)
    !$past(regRd) |-> regRdata == 8'h00)
    else $error("read data shown without read");

  a_high_zero: assert property (
    @(posedge sys_clk) disable iff (rst)
    $past(regRd) && ($past(regAddr) == ADDR_CNT_HI ||
      $past(regAddr) == ADDR_CMPA_HI) |-> regRdata[7:2] == 6'h00)
    else $error("unused high bits not zero");

  a_cnt_hi_read: assert property (
    @(posedge sys_clk) disable iff (rst)
    $past(regRd) && $past(regAddr) == ADDR_CNT_HI
    |-> regRdata[1:0] == $past(count_q[9:8]))
    else $error("counter high byte wrong");

  a_cnt_lo_read: assert property (
    @(posedge sys_clk) disable iff (rst)
    $past(regRd) && $past(regAddr) == ADDR_CNT_LO
    |-> regRdata == $past(loBuf_q))
    else $error("counter low byte not from buffer");

  a_buf_latch: assert property (
    @(posedge sys_clk) disable iff (rst)
    regRd && regAddr == ADDR_CNT_HI |=> loBuf_q == $past(count_q[7:0]))
    else $error("high read did not latch low byte");

  a_lo_write: assert property (
    @(posedge sys_clk) disable iff (rst)
    regWr && regAddr == ADDR_CMPA_LO
    |=> loBuf_q == $past(regWdata) && $stable(cmpA_q))
    else $error("low byte write not buffered");

  a_cmpa_commit: assert property (
    @(posedge sys_clk) disable iff (rst)
    regWr && regAddr == ADDR_CMPA_HI
    |=> cmpA_q == {$past(regWdata[1:0]), $past(loBuf_q)})
    else $error("compare a commit wrong");

  a_ctrl_write: assert property (
    @(posedge sys_clk) disable iff (rst)
    regWr && regAddr == ADDR_CTRL2 |=> ctrl2_q == $past(regWdata))
    else $error("control write lost");
endmodule : ptc_timer

// *** sim/tb_ptc_timer.sv ***
// self-checking bench for the periodic timer pin control block
`timescale 1ns/1ps
module tb_ptc_timer;
  import ptc_pkg::*;
  logic             sys_clk, rst, regWr, regRd, onCtl, tick, p;
  logic             capPin, extPin, spStop, outPin, capEv, mA, mP;
  logic [2:0]       regAddr;
  logic [7:0]       regWdata, regRdata, hi, lo;
  logic [CNT_W-1:0] cmpP, cmpA;
  logic [15:0]      v, e;
  logic [1:0]       md;
  int               n_fail, num_checks, cyc, evCnt, n;
  int               aCnt, pCnt, sCnt, c0, c1;

  ptc_timer DUT (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .counterOnControl(onCtl), .countTick(tick), .compareP(cmpP),
    .singlePulseStop(spStop), .captureInputPin(capPin),
    .externalClockPin(extPin), .timerOutputPin(outPin),
    .captureEvent(capEv), .matchA(mA), .matchP(mP));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // the whole run needs well under 10000 cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (capEv === 1'b1) evCnt <= evCnt + 1;
    if (mA === 1'b1) aCnt <= aCnt + 1;
    if (mP === 1'b1) pCnt <= pCnt + 1;
    if (spStop === 1'b1) sCnt <= sCnt + 1;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end

  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  task check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr    <= 1'b0;
  endtask : wr

  task rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd   <= 1'b0;
    #1 d = regRdata;
  endtask : rd

  // high byte first so the low byte comes from the latched copy
  task rdPair(input logic [2:0] ha, output logic [15:0] r);
    rd(ha, hi);
    rd(ha - 3'h1, lo);
    r = {hi, lo};
  endtask : rdPair

  task pulses(input int k);
    repeat (k) begin
      @(posedge sys_clk);
      tick <= 1'b1;
      @(posedge sys_clk);
      tick <= 1'b0;
    end
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : pulses

  // control is only rewritten while the timer is off
  task cfg(input logic [7:0] c);
    @(posedge sys_clk);
    onCtl <= 1'b0;
    wr(ADDR_CTRL2, c);
    @(posedge sys_clk);
    onCtl <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : cfg

  task pinPulse(input logic s);
    @(posedge sys_clk);
    {extPin, capPin} <= s ? 2'h2 : 2'h1;
    repeat (3) @(posedge sys_clk);
    {extPin, capPin} <= 2'h0;
    repeat (4) @(posedge sys_clk);
  endtask : pinPulse

  function automatic logic expPin(logic [1:0] f, logic i);
    case (f)
      PFS_00:  return i;
      PFS_01:  return 1'b0;
      PFS_10:  return 1'b1;
      default: return ~i;
    endcase
  endfunction : expPin

  initial begin
    {rst, regWr, regRd, onCtl, tick, capPin, extPin} = 7'h40;
    {regAddr, regWdata} = 11'h000;
    void'($urandom(32'h758e4bca));
    // p above the short counts keeps p match and overflow out of reach
    cmpP = 10'h100 + 10'($urandom % 700);
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rdPair(ADDR_CNT_HI, v);
    check(v, 16'h0000);
    rdPair(ADDR_CMPA_HI, v);
    check(v, 16'h0000);
    rd(ADDR_CTRL2, lo);
    check(lo, CTRL2_RESET);
    repeat (4) begin
      hi = 8'($urandom);
      lo = 8'($urandom);
      e = {6'h00, hi[1:0], lo};
      wr(ADDR_CMPA_LO, lo);
      wr(ADDR_CMPA_HI, hi);
      rdPair(ADDR_CMPA_HI, v);
      check(v, e);
      wr(ADDR_CMPA_LO, ~e[7:0]);
      rdPair(ADDR_CMPA_HI, v);
      check(v, e);
      e[7:0] = 8'($urandom);
      wr(ADDR_CTRL2, e[7:0]);
      rd(ADDR_CTRL2, lo);
      check(lo, e[7:0]);
    end
    rd(3'h7, lo);
    check(lo, 8'h00);
    for (int k = 0; k < 9; k++) begin
      md = (k % 3 == 0) ? MODE_CMP : ((k % 3 == 1) ? MODE_TMR : MODE_PWM);
      cmpA = 10'(2 + $urandom % 8);
      n = $urandom % 30;
      wr(ADDR_CMPA_LO, cmpA[7:0]);
      wr(ADDR_CMPA_HI, {6'h00, cmpA[9:8]});
      cfg({md, PFS_00, 3'h0, k[0]});
      c0 = aCnt;
      c1 = pCnt;
      pulses(n);
      @(posedge sys_clk);
      onCtl <= 1'b0;
      pulses(2);
      rdPair(ADDR_CNT_HI, v);
      e = (k[0] && md != MODE_PWM) ? 16'(n % (cmpA + 1)) : 16'(n);
      check(v, e);
      e = (k[0] && md != MODE_PWM) ? 16'(n / (cmpA + 1)) : 16'(n > cmpA);
      check(16'(aCnt - c0), e);
      check(16'(pCnt - c1), 16'h0000);
    end
    wr(ADDR_CMPA_LO, 8'h02);
    wr(ADDR_CMPA_HI, 8'h00);
    for (int k = 0; k < 16; k++) begin
      md = k[3] ? MODE_PWM : MODE_CMP;
      p = 1'($urandom);
      cfg({md, k[1:0], k[2], p, 2'h0});
      if (!k[3]) begin
        check(outPin, k[2] ^ p);
        pulses(3);
        check(outPin, expPin(k[1:0], k[2]) ^ p);
        cfg({md, k[1:0], k[2], p, 2'h0});
        check(outPin, k[2] ^ p);
      end else if (k[1:0] == PFS_11) begin
        check(outPin, k[2] ^ p);
        c0 = sCnt;
        pulses(3);
        check(outPin, 1'(~k[2] ^ p));
        check(16'(sCnt - c0), 16'h0001);
      end else if (!k[1]) begin
        check(outPin, 1'((k[0] ? k[2] : ~k[2]) ^ p));
      end else begin
        check(outPin, k[2] ^ p);
        pulses(3);
        check(outPin, 1'(~k[2] ^ p));
      end
    end
    cfg({MODE_TMR, PFS_00, 4'hC});
    check(outPin, 1'b0);
    for (int k = 0; k < 8; k++) begin
      cfg({MODE_CAP, k[1:0], 2'h0, k[2], 1'b0});
      c0 = evCnt;
      pinPulse(~k[2]);
      pinPulse(k[2]);
      #1;
      e = (k[1:0] == PFS_11) ? 16'h0 : ((k[1:0] == PFS_10) ? 16'h2 : 16'h1);
      check(16'(evCnt - c0), e);
    end
    complete_run();
  end
endmodule : tb_ptc_timer
